// ### trb_consts.svh
`ifndef TRB_CONSTS_SVH
`define TRB_CONSTS_SVH

// Instance count: index 0 is the type A timer, indices 1..4 are type B
`define TRB_NUM_TIMERS      5
`define TRB_ADDR_W          12

// Timer region address fields
`define TRB_IDX_SHIFT       6
`define TRB_KIND_SHIFT      4
`define TRB_OP_SHIFT        2
`define TRB_KIND_CON        2'h0
`define TRB_KIND_CNT        2'h1
`define TRB_KIND_PER        2'h2

// Alias operations, from the low word-address bits
`define TRB_OP_BASE         2'h0
`define TRB_OP_CLR          2'h1
`define TRB_OP_SET          2'h2
`define TRB_OP_INV          2'h3

// Interrupt region pages
`define TRB_EN_PAGE         8'h40
`define TRB_FLAG_PAGE       8'h41
`define TRB_PRIO_PAGE       7'h21

// Control bit positions and implemented-bit masks
`define TRB_BIT_ON          15
`define TRB_BIT_PAIR        3
`define TRB_CON_MASK_A      16'hE0B6
`define TRB_CON_MASK_B_EVEN 16'hE0FA
`define TRB_CON_MASK_B_ODD  16'hE0F2

// Reset values and the counter maximum
`define TRB_CON_RST         16'h0000
`define TRB_CNT_RST         16'h0000
`define TRB_PER_RST         16'hFFFF
`define TRB_PRIO_RST        5'h00
`define TRB_CNT_MAX         16'hFFFF

`endif

// ### trb_pkg.sv
package trb_pkg;

    typedef logic [15:0] trb_word16_t;
    typedef logic [1:0]  trb_op_t;
    typedef logic [4:0]  trb_prio_t;

    typedef enum logic [2:0] {
        TRB_TGT_NONE,
        TRB_TGT_TIMER,
        TRB_TGT_EN,
        TRB_TGT_FLAG,
        TRB_TGT_PRIO
    } trb_target_t;

endpackage : trb_pkg

// ### trb_timer_register_bank.sv
// Summary of operation
// R01: Every timer has its own 16-bit counter, control, count and period registers.
// R02: Count register holds count in bits 15:0; bits 31:16 read zero.
// R03: Period register holds the 16-bit value the count is compared against.
// R04: Control register uses bits 15:0 only; bits 31:16 read zero.
// R05: Control, count and period each have clear, set, invert write aliases.
// R06: Clear alias zeroes base bits where the written mask is one.
// R07: Alias reads give undefined data; software must ignore it.
// R08: Pair select bit exists only on even-numbered type B timers.
// R09: Even timer of a pair supplies prescale and control for the pair.
// R10: Each timer has one interrupt enable bit in the enable bank.
// R11: Each timer has one interrupt flag bit recording its event.
// R12: Each timer has a 3-bit interrupt priority field.
// R13: Each timer has a 2-bit interrupt subpriority beside its priority.
// R14: Software sets the pair select bit before using a 32-bit pair.
// R15: A 32-bit counter joins an even timer with the odd timer above.
// R16: Set alias forces base bits to one where the mask is one.
// R17: Invert alias toggles base bits where the mask is one.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "trb_consts.svh"
`default_nettype none

module trb_timer_register_bank
    import trb_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic [`TRB_ADDR_W-1:0] addr,
    input  wire logic [31:0]            wdata,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    output logic      [31:0]            rdata,
    output logic                        irq
);

    localparam int N = `TRB_NUM_TIMERS;

    function automatic trb_word16_t trb_con_mask(input int idx);
        if (idx == 0) begin
            return `TRB_CON_MASK_A;
        end else if ((idx % 2) == 1) begin
            return `TRB_CON_MASK_B_EVEN;
        end
        return `TRB_CON_MASK_B_ODD; // R08
    endfunction : trb_con_mask

    function automatic trb_word16_t trb_alias(input trb_word16_t old_v,
                                              input trb_word16_t mask_v,
                                              input trb_op_t     op);
        case (op)
            `TRB_OP_BASE: return mask_v;
            `TRB_OP_CLR:  return old_v & ~mask_v; // R06
            `TRB_OP_SET:  return old_v | mask_v;  // R16
            `TRB_OP_INV:  return old_v ^ mask_v;  // R17
            default:      return old_v;
        endcase
    endfunction : trb_alias

    function automatic trb_target_t trb_decode(input logic [`TRB_ADDR_W-1:0] a);
        if (a[1:0] != 2'h0) begin
            return TRB_TGT_NONE;
        end else if (a[11:9] == 3'h0 && a[8:6] < 3'(N) && a[5:4] != 2'h3) begin
            return TRB_TGT_TIMER;
        end else if (a[11:4] == `TRB_EN_PAGE) begin
            return TRB_TGT_EN;
        end else if (a[11:4] == `TRB_FLAG_PAGE && a[3:2] == `TRB_OP_BASE) begin
            return TRB_TGT_FLAG;
        end else if (a[11:5] == `TRB_PRIO_PAGE && a[4:2] < 3'(N)) begin
            return TRB_TGT_PRIO;
        end
        return TRB_TGT_NONE;
    endfunction : trb_decode

    trb_target_t tgt;
    logic [2:0]  acc_idx;
    logic [1:0]  acc_kind;
    trb_op_t     acc_op;
    logic [2:0]  prio_idx;

    assign tgt      = trb_decode(addr);
    assign acc_idx  = addr[8:6];
    assign acc_kind = addr[5:4];
    assign acc_op   = addr[3:2];
    assign prio_idx = addr[4:2];

    trb_word16_t     con_reg [N];
    trb_word16_t     cnt_reg [N];
    trb_word16_t     per_reg [N];
    trb_word16_t     cnt_next [N];
    trb_prio_t       prio_reg [N];
    logic [N-1:0]    en_reg;
    logic [N-1:0]    flag_reg;
    logic [N-1:0]    flag_next;
    logic [31:0]     rdata_reg;
    logic [N-1:0]    run_w;
    logic [N-1:0]    hit_w;
    logic [N-1:0]    step_w;
    logic [N-1:0]    evt_w;
    logic [N-1:0]    pair_w;
    logic            wr_timer;

    assign wr_timer = wr_en && (tgt == TRB_TGT_TIMER);

    // Counting engine; prescaling and gating are not modelled here
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_tmr
            logic wide_hit;
            if ((gi % 2) == 1 && gi + 1 < N) begin : g_lo
                assign pair_w[gi] = con_reg[gi][`TRB_BIT_PAIR];
                assign wide_hit   = {cnt_reg[gi+1], cnt_reg[gi]} ==
                                    {per_reg[gi+1], per_reg[gi]}; // R15
                assign run_w[gi]  = con_reg[gi][`TRB_BIT_ON];
                assign hit_w[gi]  = pair_w[gi] ? wide_hit : (cnt_reg[gi] == per_reg[gi]);
                assign step_w[gi] = 1'b1;
                // Pair event is reported on the odd half only
                assign evt_w[gi]  = run_w[gi] & hit_w[gi] & ~pair_w[gi];
            end else if ((gi % 2) == 0 && gi >= 2) begin : g_hi
                assign pair_w[gi] = 1'b0;
                assign wide_hit   = {cnt_reg[gi], cnt_reg[gi-1]} ==
                                    {per_reg[gi], per_reg[gi-1]}; // R15
                // Upper half follows the even timer's control while paired
                assign run_w[gi]  = pair_w[gi-1] ? con_reg[gi-1][`TRB_BIT_ON]
                                                 : con_reg[gi][`TRB_BIT_ON]; // R09
                assign hit_w[gi]  = pair_w[gi-1] ? wide_hit : (cnt_reg[gi] == per_reg[gi]);
                assign step_w[gi] = pair_w[gi-1] ? (cnt_reg[gi-1] == `TRB_CNT_MAX) : 1'b1;
                assign evt_w[gi]  = run_w[gi] & hit_w[gi];
            end else begin : g_solo
                assign pair_w[gi] = 1'b0;
                assign wide_hit   = 1'b0;
                assign run_w[gi]  = con_reg[gi][`TRB_BIT_ON];
                assign hit_w[gi]  = cnt_reg[gi] == per_reg[gi]; // R03
                assign step_w[gi] = 1'b1;
                assign evt_w[gi]  = run_w[gi] & hit_w[gi];
            end
            assign cnt_next[gi] = hit_w[gi]  ? `TRB_CNT_RST :
                                  step_w[gi] ? cnt_reg[gi] + 16'h0001 : cnt_reg[gi];
        end
    endgenerate

    // Control registers, only implemented bits are stored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < N; i++) begin
                con_reg[i] <= `TRB_CON_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wr_timer && acc_idx == 3'(i) && acc_kind == `TRB_KIND_CON) begin
                    con_reg[i] <= trb_alias(con_reg[i], wdata[15:0], acc_op)
                                  & trb_con_mask(i); // R04 R05 R08
                end
            end
        end
    end

    // Count registers; a software write wins over the running count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < N; i++) begin
                cnt_reg[i] <= `TRB_CNT_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wr_timer && acc_idx == 3'(i) && acc_kind == `TRB_KIND_CNT) begin
                    cnt_reg[i] <= trb_alias(cnt_reg[i], wdata[15:0], acc_op); // R01 R05
                end else if (run_w[i]) begin
                    cnt_reg[i] <= cnt_next[i]; // R01
                end
            end
        end
    end

    // Period registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < N; i++) begin
                per_reg[i] <= `TRB_PER_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wr_timer && acc_idx == 3'(i) && acc_kind == `TRB_KIND_PER) begin
                    per_reg[i] <= trb_alias(per_reg[i], wdata[15:0], acc_op); // R03 R05
                end
            end
        end
    end

    // Priority and subpriority, one word per timer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < N; i++) begin
                prio_reg[i] <= `TRB_PRIO_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wr_en && tgt == TRB_TGT_PRIO && prio_idx == 3'(i)) begin
                    prio_reg[i] <= wdata[4:0]; // R12 R13
                end
            end
        end
    end

    // Interrupt enable bank, with the same alias set as the timer registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_reg <= '0;
        end else if (wr_en && tgt == TRB_TGT_EN) begin
            en_reg <= N'(trb_alias(16'(en_reg), wdata[15:0], acc_op)); // R10
        end
    end

    // Flags: a new event beats a write-one-to-clear in the same cycle
    assign flag_next = (flag_reg & ~((wr_en && tgt == TRB_TGT_FLAG) ? wdata[N-1:0] : '0))
                       | evt_w; // R11

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign irq = |(flag_reg & en_reg); // R10 R11

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= 32'h0000_0000;
            if (rd_en) begin
                case (tgt)
                    TRB_TGT_TIMER: begin
                        // Alias reads return zero rather than garbage
                        if (acc_op != `TRB_OP_BASE) begin
                            rdata_reg <= 32'h0000_0000; // R07
                        end else if (acc_kind == `TRB_KIND_CON) begin
                            rdata_reg <= {16'h0000, con_reg[acc_idx]}; // R04
                        end else if (acc_kind == `TRB_KIND_CNT) begin
                            rdata_reg <= {16'h0000, cnt_reg[acc_idx]}; // R02
                        end else begin
                            rdata_reg <= {16'h0000, per_reg[acc_idx]}; // R03
                        end
                    end
                    TRB_TGT_EN: begin
                        if (acc_op == `TRB_OP_BASE) begin
                            rdata_reg <= {{(32-N){1'b0}}, en_reg};
                        end
                    end
                    TRB_TGT_FLAG: rdata_reg <= {{(32-N){1'b0}}, flag_reg};
                    TRB_TGT_PRIO: rdata_reg <= {27'h000_0000, prio_reg[prio_idx]};
                    default:      rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign rdata = rdata_reg;

    // Checks
    localparam logic [11:0] A_T2_CON_CLR = 12'h044;
    localparam logic [11:0] A_T1_PER_SET = 12'h028;
    localparam logic [11:0] A_T1_PER_INV = 12'h02C;
    localparam logic [11:0] A_T1_CNT     = 12'h010;
    localparam logic [11:0] A_T1_CON     = 12'h000;
    localparam logic [11:0] A_T1_CON_SET = 12'h008;
    localparam logic [11:0] A_PRIO_T1    = 12'h420;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_clr_alias_effect: assert property ( // R06
        wr_en && addr == A_T2_CON_CLR |=>
            con_reg[1] == ($past(con_reg[1]) & ~$past(wdata[15:0])))
        else $error("Clear alias did not clear masked bits");

    a_set_alias_effect: assert property ( // R16
        wr_en && addr == A_T1_PER_SET |=>
            per_reg[0] == ($past(per_reg[0]) | $past(wdata[15:0])))
        else $error("Set alias did not set masked bits");

    a_inv_alias_effect: assert property ( // R17
        wr_en && addr == A_T1_PER_INV |=>
            per_reg[0] == ($past(per_reg[0]) ^ $past(wdata[15:0])))
        else $error("Invert alias did not toggle masked bits");

    a_alias_read_zero: assert property ( // R07
        rd_en && tgt == TRB_TGT_TIMER && acc_op != `TRB_OP_BASE |=> rdata == 32'h0000_0000)
        else $error("Alias read returned nonzero data");

    a_count_read_upper: assert property ( // R02
        rd_en && addr == A_T1_CNT |=> rdata[31:16] == 16'h0000 && rdata[15:0] == $past(cnt_reg[0]))
        else $error("Count read data wrong");

    a_con_read_upper: assert property ( // R04
        rd_en && tgt == TRB_TGT_TIMER && acc_kind == `TRB_KIND_CON && acc_op == `TRB_OP_BASE
        |=> rdata[31:16] == 16'h0000)
        else $error("Control read upper half not zero");

    a_odd_no_pair_bit: assert property ( // R08
        wr_en && addr == 12'h088 |=> !con_reg[2][`TRB_BIT_PAIR] && !con_reg[0][`TRB_BIT_PAIR])
        else $error("Pair bit stored on timer without it");

    a_con_mask_kept: assert property ( // R04 R08
        (con_reg[0] & ~`TRB_CON_MASK_A) == 16'h0000
        && (con_reg[2] & ~`TRB_CON_MASK_B_ODD) == 16'h0000
        && (con_reg[4] & ~`TRB_CON_MASK_B_ODD) == 16'h0000)
        else $error("Unimplemented control bit stored");

    a_count_step_one: assert property ( // R01
        run_w[0] && !hit_w[0] && !(wr_timer && acc_idx == 3'h0 && acc_kind == `TRB_KIND_CNT)
        |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
        else $error("Counter did not advance by one");

    a_period_wrap_flag: assert property ( // R03 R11
        run_w[0] && hit_w[0] && !(wr_timer && acc_idx == 3'h0 && acc_kind == `TRB_KIND_CNT)
        |=> cnt_reg[0] == 16'h0000 && flag_reg[0])
        else $error("Period match did not wrap and flag");

    a_per_read_data: assert property ( // R03
        rd_en && tgt == TRB_TGT_TIMER && acc_kind == `TRB_KIND_PER && acc_op == `TRB_OP_BASE
        |=> rdata == {16'h0000, $past(per_reg[acc_idx])})
        else $error("Period read data wrong");

    a_flag_set_wins: assert property ( // R11
        evt_w[1] && wr_en && tgt == TRB_TGT_FLAG && wdata[1] |=> flag_reg[1])
        else $error("Event lost against flag clear");

    a_flag_w1c_clear: assert property ( // R11
        wr_en && tgt == TRB_TGT_FLAG && evt_w == '0
        |=> (flag_reg & $past(wdata[N-1:0])) == '0)
        else $error("Written one did not clear its flag");

    a_irq_from_enable: assert property ( // R10
        en_reg == '0 || flag_reg == '0 |-> !irq)
        else $error("Interrupt not gated by enable bank");

    a_irq_raised: assert property ( // R10 R11
        flag_reg[0] && en_reg[0] |-> irq)
        else $error("Enabled pending flag gave no interrupt");

    a_en_alias_clear: assert property ( // R06 R10
        wr_en && tgt == TRB_TGT_EN && acc_op == `TRB_OP_CLR
        |=> en_reg == ($past(en_reg) & ~$past(wdata[N-1:0])))
        else $error("Enable clear alias did not clear masked bits");

    // Bus master leaves one idle cycle after each strobe
    a_prio_write_field: assert property ( // R12 R13
        wr_en && addr == A_PRIO_T1 ##2 rd_en && addr == A_PRIO_T1
        |=> rdata[4:2] == $past(wdata[4:2], 3) && rdata[1:0] == $past(wdata[1:0], 3))
        else $error("Priority fields not held");

    a_prio_read_data: assert property ( // R12 R13
        rd_en && tgt == TRB_TGT_PRIO |=> rdata == {27'h000_0000, $past(prio_reg[prio_idx])})
        else $error("Priority read data wrong");

    a_pair_carry_only: assert property ( // R15
        pair_w[1] && run_w[2] && !hit_w[2] && cnt_reg[1] != `TRB_CNT_MAX
        && !(wr_timer && acc_idx == 3'h2) |=> $stable(cnt_reg[2]))
        else $error("Upper pair half moved without carry");

    a_pair_wide_wrap: assert property ( // R15
        pair_w[1] && run_w[2] && hit_w[2] && !(wr_timer && acc_kind == `TRB_KIND_CNT)
        |=> cnt_reg[1] == `TRB_CNT_RST && cnt_reg[2] == `TRB_CNT_RST && flag_reg[2])
        else $error("Joined pair did not wrap as one counter");

    a_pair_lo_silent: assert property (pair_w[1] |-> !evt_w[1]) // R09 R15
        else $error("Lower pair half raised its own event");

    c_timer_match: cover property (run_w[0] && hit_w[0] ##1 irq);
    c_pair_carry: cover property (pair_w[1] && run_w[2] && cnt_reg[1] == `TRB_CNT_MAX);
    c_set_then_clr: cover property (wr_en && addr == A_T1_CON_SET ##2 wr_en && addr == 12'h004);
    c_read_con: cover property (rd_en && addr == A_T1_CON);
    c_pair_wrap: cover property (pair_w[1] && run_w[2] && hit_w[2] ##1 flag_reg[2]);

endmodule : trb_timer_register_bank

`default_nettype wire

// ### trb_timer_register_bank_bench.sv
`timescale 1ns/10ps
`include "trb_consts.svh"
`default_nettype none

module trb_timer_register_bank_bench;
    import trb_pkg::*;

    logic                   clk;
    logic                   reset_n;
    logic [`TRB_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr_en;
    logic                   rd_en;
    logic [31:0]            rdata;
    logic                   irq;
    int                     num_errors;
    int                     tests_run;
    int                     cycles;
    trb_word16_t            model[0:15];

    trb_timer_register_bank dut (
        .clk     (clk),
        .reset_n (reset_n),
        .addr    (addr),
        .wdata   (wdata),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .rdata   (rdata),
        .irq     (irq)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard, well above the few thousand cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Entered in the time step of a rising edge; an idle cycle after each strobe
    // keeps any strobe from being driven twice in one time step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : wr

    // Read data stand only in the cycle after the strobe, so look mid-cycle
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(what, exp, rdata);
        @(posedge clk);
    endtask : rchk

    task automatic irq_chk(input string what, input logic exp);
        @(negedge clk);
        chk(what, {31'h0, exp}, {31'h0, irq});
        @(posedge clk);
    endtask : irq_chk

    function automatic trb_word16_t impl(input int i, input int k);
        if (i == 5) return 16'h001F;
        if (k != 0) return 16'hFFFF;
        if (i == 0) return `TRB_CON_MASK_A;
        if (i % 2 == 1) return `TRB_CON_MASK_B_EVEN;
        return `TRB_CON_MASK_B_ODD;
    endfunction : impl

    function automatic trb_word16_t apply(input trb_word16_t old, input trb_word16_t m,
                                          input int op, input trb_word16_t im);
        case (op)
            0: return m & im;
            1: return old & ~m;
            2: return (old | m) & im;
            default: return (old ^ m) & im;
        endcase
    endfunction : apply

    function automatic logic [11:0] reg_addr(input int i, input int k, input int op);
        if (i == 5) return 12'h400 + 12'(op * 4);
        return 12'(i * 64 + k * 16 + op * 4);
    endfunction : reg_addr

    initial begin
        int          i;
        int          k;
        int          op;
        int          slot;
        logic [31:0] d;
        num_errors = 0;
        tests_run  = 0;
        reset_n    = 1'b0;
        addr       = '0;
        wdata      = '0;
        wr_en      = 1'b0;
        rd_en      = 1'b0;
        void'($urandom(66));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 5; i++) begin
            rchk("control reset", reg_addr(i, 0, 0), 32'h0000_0000);
            rchk("count reset", reg_addr(i, 1, 0), 32'h0000_0000);
            rchk("period reset", reg_addr(i, 2, 0), 32'h0000_FFFF);
            model[i * 3] = 16'h0000;
            model[i * 3 + 1] = 16'h0000;
            model[i * 3 + 2] = 16'hFFFF;
        end
        model[15] = 16'h0000;
        rchk("enable reset", 12'h400, 32'h0000_0000);
        rchk("flag reset", 12'h410, 32'h0000_0000);
        // Random base and alias traffic; the on bit is kept low so nothing counts
        for (int n = 0; n < 300; n++) begin
            i    = $urandom % 6;
            k    = (i == 5) ? 0 : $urandom % 3;
            op   = $urandom % 4;
            d    = $urandom;
            if (k == 0 && i != 5) d[`TRB_BIT_ON] = 1'b0;
            slot = (i == 5) ? 15 : i * 3 + k;
            wr(reg_addr(i, k, op), d);
            model[slot] = apply(model[slot], d[15:0], op, impl(i, k));
            rchk("register word", reg_addr(i, k, 0), {16'h0000, model[slot]});
            if (op != 0) rchk("alias read", reg_addr(i, k, op), 32'h0000_0000);
            irq_chk("irq idle", 1'b0);
        end
        // Hand-picked alias corners on the count register of timer index 4
        wr(reg_addr(4, 1, 0), 32'hFFFF_A5C3);
        wr(reg_addr(4, 1, 1), 32'h0000_FF00);
        rchk("count clear", reg_addr(4, 1, 0), 32'h0000_00C3);
        wr(reg_addr(4, 1, 2), 32'h0000_F00F);
        rchk("count set", reg_addr(4, 1, 0), 32'h0000_F0CF);
        wr(reg_addr(4, 1, 3), 32'hFFFF_FFFF);
        rchk("count invert", reg_addr(4, 1, 0), 32'h0000_0F30);
        // Pair select exists only where it joins a pair
        for (i = 0; i < 5; i++) begin
            wr(reg_addr(i, 0, 0), 32'h0000_0008);
            rchk("pair select bit", reg_addr(i, 0, 0),
                 (i == 1 || i == 3) ? 32'h0000_0008 : 32'h0000_0000);
            wr(reg_addr(i, 0, 0), 32'h0000_0000);
        end
        rchk("unmapped read", 12'h800, 32'h0000_0000);
        wr(12'h003, 32'h0000_00FF);
        rchk("misaligned write", 12'h000, 32'h0000_0000);
        wr(12'h008, 32'h0000_0006);
        wr(12'h004, 32'h0000_0002);
        rchk("control set then clear", 12'h000, 32'h0000_0004);
        for (i = 0; i < 5; i++) begin
            d = $urandom;
            wr(12'h420 + 12'(i * 4), d);
            rchk("priority word", 12'h420 + 12'(i * 4), {27'h0, d[4:0]});
        end
        // Timer index 0 wraps at its period and raises its flag
        wr(12'h400, 32'h0000_0000);
        wr(reg_addr(0, 1, 0), 32'h0000_0000);
        wr(reg_addr(0, 2, 0), 32'h0000_0004);
        wr(reg_addr(0, 0, 0), 32'h0000_8000);
        repeat (12) @(posedge clk);
        irq_chk("irq masked", 1'b0);
        wr(12'h408, 32'h0000_0001);
        irq_chk("irq unmasked", 1'b1);
        wr(reg_addr(0, 0, 1), 32'h0000_8000);
        rchk("flag after wrap", 12'h410, 32'h0000_0001);
        wr(12'h410, 32'h0000_0001);
        rchk("flag cleared", 12'h410, 32'h0000_0000);
        irq_chk("irq cleared", 1'b0);
        // Index 1 and index 2 joined: only the upper half flags
        wr(reg_addr(1, 1, 0), 32'h0000_0000);
        wr(reg_addr(2, 1, 0), 32'h0000_0000);
        wr(reg_addr(1, 2, 0), 32'h0000_0002);
        wr(reg_addr(2, 2, 0), 32'h0000_0000);
        wr(reg_addr(1, 0, 0), 32'h0000_0008);
        wr(reg_addr(1, 0, 2), 32'h0000_8000);
        repeat (12) @(posedge clk);
        wr(reg_addr(1, 0, 1), 32'h0000_8000);
        rchk("pair flag", 12'h410, 32'h0000_0004);
        rchk("pair high half", reg_addr(2, 1, 0), 32'h0000_0000);
        stop_test();
    end

endmodule : trb_timer_register_bank_bench

`default_nettype wire
